//--- cgen_top.sv
// clock generator control: registers over ahb-lite, pll digital loop, base clock selector
// assumes crystal and vco arrive as one-cycle tick enables on the system clock
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "cgen_regs.svh"
module cgen_top #(
  parameter int WINDOW = 64
) (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic                  osc_enable_from_integration,
  input  wire logic                  crystal_tick,
  input  wire logic                  vco_tick,
  input  wire logic                  crystal_lost,
  output logic                       osc_run,
  output logic                       base_clock_out,
  output logic                       vco_feedback_clock,
  output logic                       pump_up,
  output logic                       pump_down,
  output logic                       tracking_mode,
  output logic      [3:0]            vco_range,
  output logic                       pll_enable,
  output logic                       pll_irq
);
  import cgen_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic       pll_irq_enable, pll_irq_flag, pll_power_on, base_clock_select;
  logic       auto_mode, lock_flag, tracking_select, crystal_loss_detect;
  logic [3:0] feedback_multiplier, range_multiplier;
  logic       wr_pend;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic       near_lock, near_track, window_done, fb_tick, pu, pd;
  logic       pll_active;
  logic       lock_prev;

  function automatic logic [7:0] word_index(input logic [31:0] a);
    word_index = a[9:2];
  endfunction : word_index

  // range zero stops the loop outright, whatever the power bit says
  assign pll_active = pll_power_on && (range_multiplier != 4'h0);

  // ****************************************
  // ahb-lite slave, zero wait, always okay
  // ****************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 8'h00;
      rd_idx  <= 8'h00;
    end else if (hready) begin
      // hsize not decoded: only whole aligned words are expected
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_idx  <= word_index(haddr);
      rd_idx  <= word_index(haddr);
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      // launched at the address edge, so it stands through the data phase
      if (hready && hsel && htrans[1] && !hwrite) begin
        case (word_index(haddr))
          `CGEN_IDX_CTRL: hrdata <= {24'h0, pll_irq_enable, pll_irq_flag, pll_power_on,
                                     base_clock_select, `CGEN_CTRL_RSVD};
          `CGEN_IDX_BW: hrdata <= {24'h0, auto_mode, lock_flag, tracking_select,
                                   crystal_loss_detect, `CGEN_BW_RSVD};
          `CGEN_IDX_PROG: hrdata <= {24'h0, feedback_multiplier, range_multiplier};
          `CGEN_IDX_STATUS: hrdata <= {29'h0, near_track, tracking_mode, base_clock_out};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control register with interlocks between power and selection
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pll_irq_enable    <= 1'b0;
      pll_power_on      <= 1'b1;
      base_clock_select <= 1'b0;
    end else begin
      if (wr_pend && wr_idx == `CGEN_IDX_CTRL) begin
        pll_irq_enable <= hwdata[`CGEN_CTRL_IE];
        // power may change only while crystal is selected and select is unchanged
        if (hwdata[`CGEN_CTRL_BCS] == base_clock_select && !base_clock_select)
          pll_power_on <= hwdata[`CGEN_CTRL_ON];
        // select may be set only while power is unchanged and the loop can run, and cleared whenever power is unchanged
        if (hwdata[`CGEN_CTRL_ON] == pll_power_on) begin
          if (!hwdata[`CGEN_CTRL_BCS])
            base_clock_select <= 1'b0;
          else if (pll_active)
            base_clock_select <= 1'b1;
        end
      end
      // range zero kills the vco, so the crystal is forced back
      if (range_multiplier == 4'h0)
        base_clock_select <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      auto_mode           <= 1'b0;
      crystal_loss_detect <= 1'b0;
      feedback_multiplier <= 4'h6;
      range_multiplier    <= 4'h6;
    end else if (wr_pend) begin
      if (wr_idx == `CGEN_IDX_BW) begin
        auto_mode           <= hwdata[`CGEN_BW_AUTO];
        crystal_loss_detect <= hwdata[`CGEN_BW_XLD];
      end
      if (wr_idx == `CGEN_IDX_PROG) begin
        feedback_multiplier <= hwdata[7:4];
        range_multiplier    <= hwdata[3:0];
      end
    end
  end

  // ****************************************
  // loop: divider, detector, mode and lock
  // ****************************************
  cgen_divider u_div (
    .clock    (clock),
    .resetn   (resetn),
    .tick_in  (vco_tick && pll_active),
    .modulus  (feedback_multiplier),
    .tick_out (fb_tick)
  );

  // no crystal, no reference windows: lock simply stops updating
  cgen_detector #(.WINDOW(WINDOW)) u_det (
    .clock       (clock),
    .resetn      (resetn),
    .enable      (pll_active),
    .ref_tick    (crystal_tick && osc_enable_from_integration),
    .fb_tick     (fb_tick),
    .pump_up     (pu),
    .pump_down   (pd),
    .near_lock   (near_lock),
    .near_track  (near_track),
    .window_done (window_done)
  );

  always_ff @(posedge clock) begin
    if (!resetn) begin
      tracking_select <= 1'b0;
      lock_flag       <= 1'b0;
    end else if (!pll_active) begin
      tracking_select <= 1'b0;
      lock_flag       <= 1'b0;
    end else if (auto_mode) begin
      if (window_done) begin
        tracking_select <= near_track;
        lock_flag       <= near_lock;
      end
    end else begin
      lock_flag <= 1'b0;
      if (wr_pend && wr_idx == `CGEN_IDX_BW)
        tracking_select <= hwdata[`CGEN_BW_TRK];
    end
  end

  // interrupt flag: set on lock toggle, cleared when disabled or manual
  always_ff @(posedge clock) begin
    if (!resetn) begin
      lock_prev    <= 1'b0;
      pll_irq_flag <= 1'b0;
    end else begin
      lock_prev <= lock_flag;
      if (pll_irq_enable && auto_mode && lock_flag != lock_prev)
        pll_irq_flag <= 1'b1;
      else if (!pll_irq_enable || !auto_mode)
        pll_irq_flag <= 1'b0;
    end
  end

  // ****************************************
  // base clock selector
  // ****************************************
  cgen_sel_t  sel_state;
  logic       cur_src;
  logic [1:0] x_cnt, v_cnt;
  logic       src_tick;

  assign src_tick = cur_src ? vco_tick : (crystal_tick && osc_enable_from_integration);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sel_state <= CGEN_SEL_RUN;
      cur_src   <= 1'b0;
      x_cnt     <= 2'd0;
      v_cnt     <= 2'd0;
    end else begin
      case (sel_state)
        CGEN_SEL_RUN: begin
          x_cnt <= 2'd0;
          v_cnt <= 2'd0;
          if (base_clock_select != cur_src) sel_state <= CGEN_SEL_STOP_OLD;
        end
        CGEN_SEL_STOP_OLD: begin
          // output held while counting up to three edges of each clock
          if (crystal_tick && x_cnt != 2'd`CGEN_SW_CYCLES) x_cnt <= x_cnt + 2'd1;
          if (vco_tick && v_cnt != 2'd`CGEN_SW_CYCLES) v_cnt <= v_cnt + 2'd1;
          // a stopped vco never ticks again, so its count is waived then
          if (x_cnt == 2'd`CGEN_SW_CYCLES &&
              (v_cnt == 2'd`CGEN_SW_CYCLES || !pll_active))
            sel_state <= CGEN_SEL_START_NEW;
        end
        CGEN_SEL_START_NEW: begin
          cur_src   <= base_clock_select;
          sel_state <= CGEN_SEL_RUN;
        end
        default: sel_state <= CGEN_SEL_RUN;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      base_clock_out <= 1'b0;
    end else if (sel_state == CGEN_SEL_RUN && src_tick) begin
      base_clock_out <= !base_clock_out;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      osc_run            <= 1'b0;
      vco_feedback_clock <= 1'b0;
      pump_up            <= 1'b0;
      pump_down          <= 1'b0;
      tracking_mode      <= 1'b0;
      vco_range          <= 4'h6;
      pll_enable         <= 1'b0;
      pll_irq            <= 1'b0;
    end else begin
      // one cycle late on purpose: every output leaves a flip-flop
      osc_run            <= osc_enable_from_integration;
      vco_feedback_clock <= fb_tick;
      pump_up            <= pu;
      pump_down          <= pd;
      tracking_mode      <= pll_active && tracking_select;
      vco_range          <= range_multiplier;
      pll_enable         <= pll_active;
      pll_irq            <= pll_irq_flag;
    end
  end

  sel_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    sel_state == CGEN_SEL_STOP_OLD |=> $stable(base_clock_out))
    else $error("base clock moved during switch");
  sel_take_a: assert property (@(posedge clock) disable iff (!resetn)
    sel_state == CGEN_SEL_START_NEW |=> cur_src == $past(base_clock_select))
    else $error("new source not taken");
  vco_off_a: assert property (@(posedge clock) disable iff (!resetn)
    base_clock_select |-> pll_power_on) else $error("vco selected while off");
  range_zero_a: assert property (@(posedge clock) disable iff (!resetn)
    range_multiplier == 4'h0 |=> !base_clock_select)
    else $error("vco kept with zero range");
  acq_read_a: assert property (@(posedge clock) disable iff (!resetn)
    !pll_active |=> !tracking_select) else $error("tracking bit set while idle");
  mode_auto_a: assert property (@(posedge clock) disable iff (!resetn)
    pll_active && auto_mode && window_done |=> tracking_select == $past(near_track))
    else $error("auto mode missed a window");
  lock_manual_a: assert property (@(posedge clock) disable iff (!resetn)
    !auto_mode |=> !lock_flag) else $error("lock shown in manual mode");
  irq_set_a: assert property (@(posedge clock) disable iff (!resetn)
    pll_irq_enable && auto_mode && $changed(lock_flag) |=> ##1 pll_irq)
    else $error("lock change gave no interrupt");
  irq_clear_a: assert property (@(posedge clock) disable iff (!resetn)
    !pll_irq_enable |=> !pll_irq_flag) else $error("flag kept while disabled");
  osc_follow_a: assert property (@(posedge clock) disable iff (!resetn)
    $past(resetn) |-> osc_run == $past(osc_enable_from_integration))
    else $error("osc run lag");
  track_out_a: assert property (@(posedge clock) disable iff (!resetn)
    pll_active && tracking_select |=> tracking_mode) else $error("tracking not shown");
  reset_val_a: assert property (@(posedge clock)
    !resetn |=> !base_clock_select && pll_power_on && feedback_multiplier == 4'h6)
    else $error("reset values wrong");
  read_rsvd_a: assert property (@(posedge clock) disable iff (!resetn)
    hready && hsel && htrans[1] && !hwrite && word_index(haddr) == `CGEN_IDX_CTRL
    |=> hrdata[3:0] == 4'hF) else $error("reserved bits read wrong");
endmodule : cgen_top

//--- cgen_regs.svh
// constants for the clock generator control block: offsets, fields, resets, counts
// assumes inclusion by the design files and the bench of this block only
`ifndef CGEN_REGS_SVH
`define CGEN_REGS_SVH
// printed offsets are not word multiples: these are indices, byte address = 4 x index
`define CGEN_IDX_CTRL     8'h1C
`define CGEN_IDX_BW       8'h1D
`define CGEN_IDX_PROG     8'h1E
`define CGEN_IDX_STATUS   8'h1F
`define CGEN_RST_CTRL     8'h2F
`define CGEN_RST_BW       8'h00
`define CGEN_RST_PROG     8'h66
`define CGEN_CTRL_IE      7
`define CGEN_CTRL_IF      6
`define CGEN_CTRL_ON      5
`define CGEN_CTRL_BCS     4
`define CGEN_BW_AUTO      7
`define CGEN_BW_LOCK      6
`define CGEN_BW_TRK       5
`define CGEN_BW_XLD       4
`define CGEN_CTRL_RSVD    4'hF
`define CGEN_BW_RSVD      4'h0
`define CGEN_F_NOM_HZ     32'd4915200
`define CGEN_SW_CYCLES    3
`define CGEN_LOCK_TOL     4
`define CGEN_TRK_TOL      8
`endif

//--- cgen_pkg.sv
// types shared by the clock generator control files
// assumes cgen_regs.svh sits in the same folder
package cgen_pkg;
  typedef enum logic [1:0] {CGEN_SEL_RUN, CGEN_SEL_STOP_OLD, CGEN_SEL_START_NEW} cgen_sel_t;
  typedef logic [7:0] cgen_byte_t;
endpackage : cgen_pkg

//--- cgen_divider.sv
// modulo divider of the vco enable stream by feedback multiplier
// assumes vco ticks arrive as one-cycle enables on the system clock
`timescale 1ns/1ps
`include "cgen_regs.svh"
module cgen_divider (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       tick_in,
  input  wire logic [3:0] modulus,
  output logic            tick_out
);
  import cgen_pkg::*;
  logic [3:0] count;
  logic [3:0] limit;
  assign limit = (modulus == 4'h0) ? 4'h0 : modulus - 4'h1;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      count    <= 4'h0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (count >= limit) begin
          count    <= 4'h0;
          tick_out <= 1'b1;
        end else begin
          count <= count + 4'h1;
        end
      end
    end
  end
  div_period_a: assert property (@(posedge clock) disable iff (!resetn)
    tick_out |-> $past(tick_in)) else $error("divider ticked without vco tick");
endmodule : cgen_divider

//--- cgen_detector.sv
// phase and frequency comparison of feedback and reference tick streams
// assumes both inputs are one-cycle enables on the system clock
`timescale 1ns/1ps
`include "cgen_regs.svh"
module cgen_detector #(
  parameter int WINDOW = 64
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic enable,
  input  wire logic ref_tick,
  input  wire logic fb_tick,
  output logic      pump_up,
  output logic      pump_down,
  output logic      near_lock,
  output logic      near_track,
  output logic      window_done
);
  import cgen_pkg::*;
  logic [15:0] ref_cnt;
  logic [15:0] fb_cnt;
  logic [15:0] diff;
  // phase: reference edge opens up pulse, feedback edge opens down pulse
  always_ff @(posedge clock) begin
    if (!resetn || !enable) begin
      pump_up   <= 1'b0;
      pump_down <= 1'b0;
    end else if (ref_tick && fb_tick) begin
      pump_up   <= 1'b0;
      pump_down <= 1'b0;
    end else if (ref_tick) begin
      if (pump_down) pump_down <= 1'b0;
      else pump_up <= 1'b1;
    end else if (fb_tick) begin
      if (pump_up) pump_up <= 1'b0;
      else pump_down <= 1'b1;
    end
  end
  assign diff = (fb_cnt > 16'(WINDOW)) ? fb_cnt - 16'(WINDOW) : 16'(WINDOW) - fb_cnt;
  // frequency: count feedback edges over a fixed count of reference edges
  always_ff @(posedge clock) begin
    if (!resetn || !enable) begin
      ref_cnt     <= 16'h0000;
      fb_cnt      <= 16'h0000;
      near_lock   <= 1'b0;
      near_track  <= 1'b0;
      window_done <= 1'b0;
    end else begin
      window_done <= 1'b0;
      if (ref_tick && ref_cnt == 16'(WINDOW - 1)) begin
        ref_cnt     <= 16'h0000;
        fb_cnt      <= {15'h0000, fb_tick};
        near_lock   <= diff <= 16'(`CGEN_LOCK_TOL);
        near_track  <= diff <= 16'(`CGEN_TRK_TOL);
        window_done <= 1'b1;
      end else begin
        if (ref_tick) ref_cnt <= ref_cnt + 16'h0001;
        if (fb_tick) fb_cnt <= fb_cnt + 16'h0001;
      end
    end
  end
  pump_excl_a: assert property (@(posedge clock) disable iff (!resetn)
    !(pump_up && pump_down)) else $error("both pump directions at once");
  lock_track_a: assert property (@(posedge clock) disable iff (!resetn)
    near_lock |-> near_track) else $error("lock without track tolerance");
endmodule : cgen_detector

//--- cgen_clock_source.sv
// crystal and vco stand-in: one-cycle tick enables at bench-chosen spacing
// assumes the system clock of the bench and the run/enable levels of the block
`timescale 1ns/1ps
module cgen_clock_source (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       osc_run,
  input  wire logic       pll_enable,
  input  wire logic [7:0] xtal_gap,
  input  wire logic [7:0] vco_gap,
  output logic            crystal_tick,
  output logic            vco_tick
);
  logic [7:0] xc;
  logic [7:0] vc;
  // ****************************************
  // tick makers
  // ****************************************
  // a stopped oscillator gives no ticks at all, not a stuck level
  always_ff @(posedge clock) begin
    if (!resetn || !osc_run) begin
      xc           <= 8'h00;
      crystal_tick <= 1'b0;
    end else begin
      crystal_tick <= (xc == xtal_gap - 8'h01);
      xc           <= (xc == xtal_gap - 8'h01) ? 8'h00 : xc + 8'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (!resetn || !pll_enable) begin
      vc       <= 8'h00;
      vco_tick <= 1'b0;
    end else begin
      vco_tick <= (vc == vco_gap - 8'h01);
      vc       <= (vc == vco_gap - 8'h01) ? 8'h00 : vc + 8'h01;
    end
  end
endmodule : cgen_clock_source

//--- cgen_top_bench.sv
// self-checking bench of the clock generator control block
// assumes cgen_top, cgen_clock_source and cgen_regs.svh in this folder
`timescale 1ns/1ps
`include "cgen_regs.svh"
module cgen_top_bench;
  typedef struct {logic wr; logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} cgen_row_t;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        osc_en = 1'b1;
  logic        xlost = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  xtal_gap = 8'h08;
  logic [7:0]  vco_gap = 8'h02;
  logic [31:0] hrdata;
  logic [3:0]  vco_range;
  logic        hreadyout, hresp, osc_run, base_clock_out, vco_feedback_clock, pump_up;
  logic        pump_down, tracking_mode, pll_enable, pll_irq, crystal_tick, vco_tick;
  logic [7:0]  rb;
  int          bad_count = 0;
  int          num_checks = 0;
  int          tg, fb, n;
  cgen_row_t   rows[9];
  always #5 clock = ~clock;
  cgen_top #(.WINDOW(8)) dut_u (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .osc_enable_from_integration(osc_en), .crystal_tick(crystal_tick), .vco_tick(vco_tick),
    .crystal_lost(xlost), .osc_run(osc_run), .base_clock_out(base_clock_out),
    .vco_feedback_clock(vco_feedback_clock), .pump_up(pump_up), .pump_down(pump_down),
    .tracking_mode(tracking_mode), .vco_range(vco_range), .pll_enable(pll_enable),
    .pll_irq(pll_irq));
  cgen_clock_source src_u (.clock(clock), .resetn(resetn), .osc_run(osc_run),
    .pll_enable(pll_enable), .xtal_gap(xtal_gap), .vco_gap(vco_gap),
    .crystal_tick(crystal_tick), .vco_tick(vco_tick));
  // ****************************************
  // report and compare
  // ****************************************
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task chk8(input string what, input logic [7:0] ex, input logic [7:0] got);
    num_checks++;
    if (got !== ex) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, ex, got);
    end
  endtask : chk8
  task chk_bit(input string what, input logic ex, input logic got);
    chk8(what, {7'h0, ex}, {7'h0, got});
  endtask : chk_bit
  task chk_count(input string what, input int ex, input int got);
    num_checks++;
    if (got != ex) begin
      bad_count++;
      $display("unexpected %s expected %0d seen %0d", what, ex, got);
    end
  endtask : chk_count
  task edge_bounded;
    @(posedge clock);
    n++;
    if (n > 400) begin
      bad_count++;
      $display("unexpected wait expected done seen timeout");
      give_verdict;
    end
  endtask : edge_bounded
  // ****************************************
  // ahb-lite single word transfer
  // ****************************************
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    edge_bounded;
    while (hreadyout !== 1'b1) edge_bounded;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    edge_bounded;
    while (hreadyout !== 1'b1) edge_bounded;
    rb = hrdata[7:0];
  endtask : bus
  task count(input int cyc);
    logic last;
    tg = 0;
    fb = 0;
    last = base_clock_out;
    repeat (cyc) begin
      @(posedge clock);
      if (base_clock_out !== last) tg++;
      last = base_clock_out;
      if (vco_feedback_clock === 1'b1) fb++;
    end
  endtask : count
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rows = '{'{0, `CGEN_IDX_CTRL, 8'h00, 8'h2F}, '{0, `CGEN_IDX_BW, 8'h00, 8'h00},
      '{0, `CGEN_IDX_PROG, 8'h00, 8'h66}, '{1, `CGEN_IDX_PROG, 8'hA5, 8'hA5},
      '{1, `CGEN_IDX_BW, 8'h1F, 8'h10}, '{1, `CGEN_IDX_CTRL, 8'h0F, 8'h0F},
      '{1, `CGEN_IDX_CTRL, 8'h20, 8'h2F}, '{1, 8'h20, 8'hFF, 8'h00},
      '{1, `CGEN_IDX_PROG, 8'h46, 8'h46}};
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      if (rows[i].wr) bus(1'b1, rows[i].idx, rows[i].wd);
      bus(1'b0, rows[i].idx, 8'h00);
      chk8("register", rows[i].ex, rb);
    end
    chk8("range", 8'h06, {4'h0, vco_range});
    count(80);
    chk_count("crystal half", 10, tg);
    osc_en <= 1'b0;
    repeat (3) @(posedge clock);
    chk_bit("osc run off", 1'b0, osc_run);
    osc_en <= 1'b1;
    repeat (3) @(posedge clock);
    chk_bit("osc run on", 1'b1, osc_run);
    bus(1'b1, `CGEN_IDX_BW, 8'h20);
    bus(1'b0, `CGEN_IDX_BW, 8'h00);
    chk8("manual track", 8'h20, rb);
    chk_bit("track mode", 1'b1, tracking_mode);
    bus(1'b1, `CGEN_IDX_BW, 8'h00);
    bus(1'b0, `CGEN_IDX_BW, 8'h00);
    chk_bit("acquire mode", 1'b0, tracking_mode);
    // interrupt enabled before auto, so the lock edge must be flagged
    bus(1'b1, `CGEN_IDX_CTRL, 8'hA0);
    bus(1'b1, `CGEN_IDX_BW, 8'h80);
    for (int k = 0; k < 300 && rb[6] !== 1'b1; k++) bus(1'b0, `CGEN_IDX_BW, 8'h00);
    chk_bit("lock", 1'b1, rb[6]);
    chk_bit("auto track", 1'b1, rb[5]);
    chk_bit("auto track out", 1'b1, tracking_mode);
    bus(1'b0, `CGEN_IDX_STATUS, 8'h00);
    chk8("status", 8'h06, rb & 8'h06);
    bus(1'b0, `CGEN_IDX_CTRL, 8'h00);
    chk_bit("irq flag", 1'b1, rb[6]);
    chk_bit("irq line", 1'b1, pll_irq);
    bus(1'b1, `CGEN_IDX_CTRL, 8'hB0);
    bus(1'b0, `CGEN_IDX_CTRL, 8'h00);
    chk_bit("select", 1'b1, rb[4]);
    count(40);
    count(40);
    chk_count("vco half", 20, tg);
    foreach (rows[i]) begin
      rows[i].wd = (i == 0) ? 8'h80 : (i == 1) ? 8'hA0 : (i == 2) ? 8'h80 : 8'h90;
      rows[i].ex = (i == 0) ? 8'h30 : (i == 1) ? 8'h20 : 8'h00;
      if (i < 4) begin
        bus(1'b1, `CGEN_IDX_CTRL, rows[i].wd);
        bus(1'b0, `CGEN_IDX_CTRL, 8'h00);
        chk8("power select", rows[i].ex, rb & 8'h30);
      end
    end
    chk_bit("pll off", 1'b0, pll_enable);
    chk_bit("pump idle", 1'b0, pump_up | pump_down);
    bus(1'b1, `CGEN_IDX_CTRL, 8'hA0);
    vco_gap <= 8'h04;
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, `CGEN_IDX_PROG, (m == 0) ? 8'h06 : 8'h26);
      count(16);
      count(80);
      chk_count("feedback", (m == 0) ? 20 : 10, fb);
    end
    bus(1'b1, `CGEN_IDX_PROG, 8'h40);
    bus(1'b1, `CGEN_IDX_CTRL, 8'hB0);
    bus(1'b0, `CGEN_IDX_CTRL, 8'h00);
    chk_bit("range zero select", 1'b0, rb[4]);
    chk_bit("range zero pll", 1'b0, pll_enable);
    bus(1'b1, `CGEN_IDX_PROG, 8'h03);
    repeat (2) @(posedge clock);
    chk8("range", 8'h03, {4'h0, vco_range});
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    bus(1'b0, `CGEN_IDX_CTRL, 8'h00);
    chk8("ctrl after reset", 8'h2F, rb);
    bus(1'b0, `CGEN_IDX_PROG, 8'h00);
    chk8("prog after reset", 8'h66, rb);
    chk_bit("reset mode", 1'b0, tracking_mode);
    give_verdict;
  end
endmodule : cgen_top_bench
